// ### verilog/sgif_flags.v
// sticky supply-fault and pin event flags with an avalon-mm register port
// assumes fault conditions and pin levels are synchronous to clk and already debounced
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "sgif_map.vh"

module sgif_flags (
    // clock and reset
    input wire clk,
    input wire rst_n,
    input wire ce,
    // avalon-mm slave
    input wire [`SGIF_ADDR_W-1:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [`SGIF_DATA_W-1:0] avs_writedata,
    input wire [`SGIF_BE_W-1:0] avs_byteenable,
    output reg [`SGIF_DATA_W-1:0] avs_readdata,
    output reg avs_waitrequest,
    // fault conditions, index 0 is unit one
    input wire [`SGIF_N_REG-1:0] reg_undervolt,
    input wire [`SGIF_N_CONV-1:0] conv_undervolt,
    input wire [`SGIF_N_HC-1:0] conv_overcurrent,
    // pin levels, index 0 is pin one
    input wire [`SGIF_N_PIN-1:0] pin_level,
    // interrupt
    output reg irq
);

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    reg [`SGIF_FLAG_W-1:0] reg_undervoltage_flags_r;
    reg [`SGIF_FLAG_W-1:0] converter_fault_flags_r;
    reg [`SGIF_FLAG_W-1:0] pin_event_flags_r;
    reg [`SGIF_FLAG_W-1:0] mask_reg_uv_r;
    reg [`SGIF_FLAG_W-1:0] mask_conv_flt_r;
    reg [`SGIF_FLAG_W-1:0] mask_pin_evt_r;
    reg [`SGIF_TRIG_W-1:0] trig_sel_r;

    reg [`SGIF_FLAG_W-1:0] reg_undervoltage_flags_nxt;
    reg [`SGIF_FLAG_W-1:0] converter_fault_flags_nxt;
    reg [`SGIF_FLAG_W-1:0] pin_event_flags_nxt;
    reg [`SGIF_DATA_W-1:0] rdata_nxt;

    wire [`SGIF_N_SRC-1:0] src_level;
    wire [2*`SGIF_N_SRC-1:0] src_mode;
    wire [`SGIF_N_SRC-1:0] src_event;

    wire [`SGIF_FLAG_W-1:0] set_reg_uv;
    wire [`SGIF_FLAG_W-1:0] set_conv_flt;
    wire [`SGIF_FLAG_W-1:0] set_pin_evt;

    wire [`SGIF_IDX_W-1:0] word_idx;
    wire req;
    wire wr_acc;
    wire [`SGIF_DATA_W-1:0] lane_mask;
    wire [`SGIF_DATA_W-1:0] wr_bits;

    wire [`SGIF_FLAG_W-1:0] pend_reg_uv;
    wire [`SGIF_FLAG_W-1:0] pend_conv_flt;
    wire [`SGIF_FLAG_W-1:0] pend_pin_evt;

    // ------------------------------------------------------------------------
    // edge detection of all sources
    // ------------------------------------------------------------------------
    // supplies are always rising-edge; pins follow their trigger select
    assign src_level = {pin_level, conv_overcurrent, conv_undervolt, reg_undervolt};
    assign src_mode = {trig_sel_r, {2*(`SGIF_N_REG+`SGIF_N_CONV+`SGIF_N_HC){1'b0}}};

    sgif_edge_det #(
        .N(`SGIF_N_SRC)
    ) u_edge (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .level(src_level),
        .mode(src_mode),
        .event_hit(src_event)
    );

    // ------------------------------------------------------------------------
    // placement of events in the flag registers
    // ------------------------------------------------------------------------
    // regulators ten..one on bits 9..0
    assign set_reg_uv = {6'h00, src_event[9:0]};
    // converter undervoltage on bits 3..0, overcurrent two..one on bits 9..8
    assign set_conv_flt = {6'h00, src_event[15:14], 4'h0, src_event[13:10]};
    // pins twelve..four on bits 11..3, pins three..one on bits 2..0
    assign set_pin_evt = {4'h0, src_event[27:16]};

    // ------------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------------
    assign word_idx = avs_address[`SGIF_ADDR_W-1:2];
    assign req = avs_read | avs_write;
    // the write lands at the edge where waitrequest is sampled low
    assign wr_acc = avs_write & ~avs_waitrequest;
    assign lane_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                        {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign wr_bits = avs_writedata & lane_mask;

    // ------------------------------------------------------------------------
    // flag next state
    // ------------------------------------------------------------------------
    // set wins over a same-cycle write-one clear
    always @*
    begin
        reg_undervoltage_flags_nxt = reg_undervoltage_flags_r;
        converter_fault_flags_nxt = converter_fault_flags_r;
        pin_event_flags_nxt = pin_event_flags_r;
        if (wr_acc && word_idx == `SGIF_IDX_REG_UV)
        begin
            reg_undervoltage_flags_nxt = reg_undervoltage_flags_nxt & ~wr_bits[`SGIF_FLAG_W-1:0];
        end
        if (wr_acc && word_idx == `SGIF_IDX_CONV_FLT)
        begin
            converter_fault_flags_nxt = converter_fault_flags_nxt & ~wr_bits[`SGIF_FLAG_W-1:0];
        end
        if (wr_acc && word_idx == `SGIF_IDX_PIN_EVT)
        begin
            pin_event_flags_nxt = pin_event_flags_nxt & ~wr_bits[`SGIF_FLAG_W-1:0];
        end
        reg_undervoltage_flags_nxt = (reg_undervoltage_flags_nxt | set_reg_uv) & `SGIF_VALID_REG_UV;
        converter_fault_flags_nxt = (converter_fault_flags_nxt | set_conv_flt) & `SGIF_VALID_CONV_FLT;
        pin_event_flags_nxt = (pin_event_flags_nxt | set_pin_evt) & `SGIF_VALID_PIN_EVT;
    end

    // ------------------------------------------------------------------------
    // flag registers
    // ------------------------------------------------------------------------
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_undervoltage_flags_r <= `SGIF_RST_FLAGS;
            converter_fault_flags_r <= `SGIF_RST_FLAGS;
            pin_event_flags_r <= `SGIF_RST_FLAGS;
        end
        else if (ce)
        begin
            reg_undervoltage_flags_r <= reg_undervoltage_flags_nxt;
            converter_fault_flags_r <= converter_fault_flags_nxt;
            pin_event_flags_r <= pin_event_flags_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // mask and trigger select registers
    // ------------------------------------------------------------------------
    // masks come up all masked; a one masks the flag from irq
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mask_reg_uv_r <= `SGIF_VALID_REG_UV;
            mask_conv_flt_r <= `SGIF_VALID_CONV_FLT;
            mask_pin_evt_r <= `SGIF_VALID_PIN_EVT;
            trig_sel_r <= `SGIF_RST_TRIG;
        end
        else if (ce && wr_acc)
        begin
            if (word_idx == `SGIF_IDX_MASK_REG_UV)
            begin
                mask_reg_uv_r <= ((mask_reg_uv_r & ~lane_mask[`SGIF_FLAG_W-1:0])
                                 | wr_bits[`SGIF_FLAG_W-1:0]) & `SGIF_VALID_REG_UV;
            end
            if (word_idx == `SGIF_IDX_MASK_CONV_FLT)
            begin
                mask_conv_flt_r <= ((mask_conv_flt_r & ~lane_mask[`SGIF_FLAG_W-1:0])
                                   | wr_bits[`SGIF_FLAG_W-1:0]) & `SGIF_VALID_CONV_FLT;
            end
            if (word_idx == `SGIF_IDX_MASK_PIN_EVT)
            begin
                mask_pin_evt_r <= ((mask_pin_evt_r & ~lane_mask[`SGIF_FLAG_W-1:0])
                                  | wr_bits[`SGIF_FLAG_W-1:0]) & `SGIF_VALID_PIN_EVT;
            end
            // pin n uses bits 2n-1..2n-2
            if (word_idx == `SGIF_IDX_TRIG_SEL)
            begin
                trig_sel_r <= (trig_sel_r & ~lane_mask[`SGIF_TRIG_W-1:0])
                              | wr_bits[`SGIF_TRIG_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // read data mux
    // ------------------------------------------------------------------------
    assign pend_reg_uv = reg_undervoltage_flags_r & ~mask_reg_uv_r;
    assign pend_conv_flt = converter_fault_flags_r & ~mask_conv_flt_r;
    assign pend_pin_evt = pin_event_flags_r & ~mask_pin_evt_r;

    // unmapped words read zero
    always @*
    begin
        rdata_nxt = `SGIF_RST_RDATA;
        case (word_idx)
            `SGIF_IDX_REG_UV:
            begin
                rdata_nxt = {16'h0000, reg_undervoltage_flags_r};
            end
            `SGIF_IDX_CONV_FLT:
            begin
                rdata_nxt = {16'h0000, converter_fault_flags_r};
            end
            `SGIF_IDX_PIN_EVT:
            begin
                rdata_nxt = {16'h0000, pin_event_flags_r};
            end
            `SGIF_IDX_MASK_REG_UV:
            begin
                rdata_nxt = {16'h0000, mask_reg_uv_r};
            end
            `SGIF_IDX_MASK_CONV_FLT:
            begin
                rdata_nxt = {16'h0000, mask_conv_flt_r};
            end
            `SGIF_IDX_MASK_PIN_EVT:
            begin
                rdata_nxt = {16'h0000, mask_pin_evt_r};
            end
            `SGIF_IDX_TRIG_SEL:
            begin
                rdata_nxt = {8'h00, trig_sel_r};
            end
            // live levels in the same layout as the flags
            `SGIF_IDX_LIVE_SUPPLY:
            begin
                rdata_nxt = {6'h00, conv_overcurrent, 4'h0, conv_undervolt, 6'h00, reg_undervolt};
            end
            `SGIF_IDX_LIVE_PIN:
            begin
                rdata_nxt = {20'h00000, pin_level};
            end
            // which flag register has an unmasked flag set
            `SGIF_IDX_PENDING:
            begin
                rdata_nxt = {29'h00000000, |pend_pin_evt, |pend_conv_flt, |pend_reg_uv};
            end
            default:
            begin
                rdata_nxt = `SGIF_RST_RDATA;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------------------
    // waitrequest idles high and drops for one cycle, one cycle after a request
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= `SGIF_RST_RDATA;
        end
        else if (ce)
        begin
            if (req && avs_waitrequest)
            begin
                avs_waitrequest <= 1'b0;
                avs_readdata <= avs_read ? rdata_nxt : `SGIF_RST_RDATA;
            end
            else
            begin
                avs_waitrequest <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // interrupt output
    // ------------------------------------------------------------------------
    // from next flag values so irq follows the flags in the same cycle
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq <= 1'b0;
        end
        else if (ce)
        begin
            irq <= |(reg_undervoltage_flags_nxt & ~mask_reg_uv_r)
                 | |(converter_fault_flags_nxt & ~mask_conv_flt_r)
                 | |(pin_event_flags_nxt & ~mask_pin_evt_r);
        end
    end

endmodule // sgif_flags
`default_nettype wire

// ### verilog/sgif_map.vh
// register map, field layout and reset values of the supply and pin event flag block
// assumes a 32-bit avalon-mm slave port with byte addressing, one register per aligned word
`ifndef SGIF_MAP_VH
`define SGIF_MAP_VH

// ----------------------------------------------------------------------------
// bus geometry
// ----------------------------------------------------------------------------
`define SGIF_ADDR_W 17
`define SGIF_IDX_W 15
`define SGIF_DATA_W 32
`define SGIF_BE_W 4

// ----------------------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------------------
`define SGIF_IDX_REG_UV 15'h4013
`define SGIF_IDX_CONV_FLT 15'h4014
`define SGIF_IDX_PIN_EVT 15'h4015
`define SGIF_IDX_MASK_REG_UV 15'h4020
`define SGIF_IDX_MASK_CONV_FLT 15'h4021
`define SGIF_IDX_MASK_PIN_EVT 15'h4022
`define SGIF_IDX_TRIG_SEL 15'h4023
`define SGIF_IDX_LIVE_SUPPLY 15'h4024
`define SGIF_IDX_LIVE_PIN 15'h4025
`define SGIF_IDX_PENDING 15'h4026

// ----------------------------------------------------------------------------
// field layout
// ----------------------------------------------------------------------------
`define SGIF_FLAG_W 16
`define SGIF_N_REG 10
`define SGIF_N_CONV 4
`define SGIF_N_HC 2
`define SGIF_N_PIN 12
`define SGIF_N_SRC 28
`define SGIF_TRIG_W 24
`define SGIF_VALID_REG_UV 16'h03FF
`define SGIF_VALID_CONV_FLT 16'h030F
`define SGIF_VALID_PIN_EVT 16'h0FFF

// ----------------------------------------------------------------------------
// trigger select encoding, two bits per pin
// ----------------------------------------------------------------------------
`define SGIF_TRIG_RISE 2'h0
`define SGIF_TRIG_FALL 2'h1
`define SGIF_TRIG_BOTH 2'h2
`define SGIF_TRIG_OFF 2'h3

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define SGIF_RST_FLAGS 16'h0000
`define SGIF_RST_TRIG 24'h000000
`define SGIF_RST_RDATA 32'h00000000

`endif

// ### verilog/sgif_edge_det.v
// per-source edge detector with a selectable trigger per source
// assumes the sources are synchronous to clk; no event in the first enabled cycle after reset
`timescale 1ns/100ps
`default_nettype none
`include "sgif_map.vh"

module sgif_edge_det #(
    parameter N = `SGIF_N_SRC
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    input wire ce,
    // sources and trigger selects
    input wire [N-1:0] level,
    input wire [2*N-1:0] mode,
    // one-cycle event per source
    output wire [N-1:0] event_hit
);

    reg [N-1:0] prev_r;
    reg armed_r;

    // ------------------------------------------------------------------------
    // history of each source
    // ------------------------------------------------------------------------
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prev_r <= {N{1'b0}};
            armed_r <= 1'b0;
        end
        else if (ce)
        begin
            prev_r <= level;
            armed_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // edge decode per source
    // ------------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < N; i = i + 1)
        begin : g_src
            wire [1:0] m = mode[2*i+1:2*i];
            wire rise = level[i] & ~prev_r[i];
            wire fall = ~level[i] & prev_r[i];
            assign event_hit[i] = armed_r & ((m == `SGIF_TRIG_RISE) ? rise :
                                             (m == `SGIF_TRIG_FALL) ? fall :
                                             (m == `SGIF_TRIG_BOTH) ? (rise | fall) : 1'b0);
        end
    endgenerate

endmodule // sgif_edge_det
`default_nettype wire

// ### dv/sgif_flags_chk.sv
// assertion checker for the supply and pin event flag block
// assumes one clock, asynchronous active-low reset, bound to the block's ports
`timescale 1ns/100ps
`default_nettype none
`include "sgif_map.vh"

module sgif_flags_chk (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // avalon-mm slave
    input wire logic [`SGIF_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [`SGIF_DATA_W-1:0] avs_writedata,
    input wire logic [`SGIF_BE_W-1:0] avs_byteenable,
    input wire logic [`SGIF_DATA_W-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    // sources
    input wire logic [`SGIF_N_REG-1:0] reg_undervolt,
    input wire logic [`SGIF_N_CONV-1:0] conv_undervolt,
    input wire logic [`SGIF_N_HC-1:0] conv_overcurrent,
    input wire logic [`SGIF_N_PIN-1:0] pin_level,
    // interrupt
    input wire logic irq
);
    // --------------------------------
    // helper logic and properties
    // --------------------------------
    logic seen_src_r;
    wire logic rd_ok = avs_read && !avs_waitrequest;
    wire logic wr_ok = avs_write && !avs_waitrequest;
    wire logic [`SGIF_IDX_W-1:0] ridx = avs_address[16:2];
    wire logic [27:0] srcs = {pin_level, conv_overcurrent, conv_undervolt, reg_undervolt};

    // set once any source has been high since reset
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            seen_src_r <= 1'b0;
        else if (|srcs)
            seen_src_r <= 1'b1;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_ANSWER_NEXT: assert property ((ce && (avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest)
        else $error("request not answered after one wait cycle");
    AST_WAIT_PULSE: assert property ((ce && !avs_waitrequest) |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    AST_REG_UV_BITS: assert property ((rd_ok && ridx == `SGIF_IDX_REG_UV) |-> avs_readdata[31:10] == 22'h000000)
        else $error("regulator flag word has bits above 9");
    AST_CONV_BITS: assert property ((rd_ok && ridx == `SGIF_IDX_CONV_FLT) |-> (avs_readdata & ~32'h0000030F) == 32'h00000000)
        else $error("converter flag word has stray bits");
    AST_PIN_BITS: assert property ((rd_ok && ridx == `SGIF_IDX_PIN_EVT) |-> avs_readdata[31:12] == 20'h00000)
        else $error("pin flag word has bits above 11");
    AST_RESET_ZERO: assert property ((rd_ok && !seen_src_r && ridx >= `SGIF_IDX_REG_UV && ridx <= `SGIF_IDX_PIN_EVT) |-> avs_readdata == 32'h00000000)
        else $error("flag set without any source activity since reset");
    // a flag clear drops irq one edge after the write, a mask write two edges after it
    AST_STICKY: assert property ($fell(irq) |-> ($past(wr_ok) || $past(wr_ok, 2)))
        else $error("interrupt dropped without a register write");
    // a source edge raises irq at the edge that samples it; an unmask write two edges later
    AST_IRQ_CAUSE: assert property ($rose(irq) |-> ($past(srcs) != $past(srcs, 2) || $past(wr_ok, 2)))
        else $error("interrupt rose without a source edge or write");
    AST_UNMAPPED: assert property ((rd_ok && ridx < `SGIF_IDX_REG_UV) |-> avs_readdata == 32'h00000000)
        else $error("unmapped word did not read zero");

    COV_IRQ: cover property ($rose(irq));
    COV_CLEAR: cover property (wr_ok && ridx == `SGIF_IDX_REG_UV);
    COV_PIN_RD: cover property (rd_ok && ridx == `SGIF_IDX_PIN_EVT && avs_readdata != 32'h00000000);
endmodule // sgif_flags_chk

bind sgif_flags sgif_flags_chk u_chk (
    .clk(clk), .rst_n(rst_n), .ce(ce), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .reg_undervolt(reg_undervolt), .conv_undervolt(conv_undervolt),
    .conv_overcurrent(conv_overcurrent), .pin_level(pin_level), .irq(irq)
);
`default_nettype wire

// ### dv/supply_gpio_irq_flags_test.sv
// self-checking bench for the supply and pin event flag block
// assumes the block answers every bus request after one wait cycle
`timescale 1ns/100ps
`default_nettype none
`include "sgif_map.vh"

module supply_gpio_irq_flags_test;
    // --------------------------------
    // stimulus, scoreboard and tasks
    // --------------------------------
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic [16:0] avs_address = 17'h00000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [3:0] avs_byteenable = 4'hF;
    wire logic [31:0] avs_readdata;
    wire logic avs_waitrequest;
    logic [9:0] reg_undervolt = 10'h000;
    logic [3:0] conv_undervolt = 4'h0;
    logic [1:0] conv_overcurrent = 2'h0;
    logic [11:0] pin_level = 12'h000;
    wire logic irq;
    int fails = 0;
    int total_checks = 0;
    int cyc = 0;
    int k;
    int j;
    logic [31:0] seed = 32'h0000E2C6;
    logic [31:0] exp_q[$];
    logic [15:0] e_reg;
    logic [15:0] e_conv;
    logic [15:0] e_pin;
    logic [23:0] trig;
    logic [31:0] r;

    sgif_flags dut (
        .clk(clk), .rst_n(rst_n), .ce(ce), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .reg_undervolt(reg_undervolt), .conv_undervolt(conv_undervolt),
        .conv_overcurrent(conv_overcurrent), .pin_level(pin_level), .irq(irq)
    );

    initial
        forever #20 clk = ~clk;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // flags a pin change raises under each pin's trigger select
    function automatic logic [11:0] hits(input logic [11:0] o, input logic [11:0] n, input logic [23:0] t);
        for (int i = 0; i < 12; i++)
            case (t[2*i +: 2])
                `SGIF_TRIG_RISE: hits[i] = n[i] & ~o[i];
                `SGIF_TRIG_FALL: hits[i] = o[i] & ~n[i];
                `SGIF_TRIG_BOTH: hits[i] = o[i] ^ n[i];
                default: hits[i] = 1'b0;
            endcase
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one bus transfer; kick raises regulator sources at the edge that takes the request, so the answer edge sets their flags
    task automatic bus(input logic wr, input logic [14:0] idx, input logic [31:0] d, input logic [3:0] be,
                       input logic [9:0] kick);
        avs_address <= {idx, 2'b00};
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clk);
        reg_undervolt <= reg_undervolt | kick;
        while (avs_waitrequest !== 1'b0)
            @(posedge clk);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [14:0] idx, input logic [31:0] d);
        bus(1'b1, idx, d, 4'hF, 10'h000);
    endtask

    task automatic rd(input logic [14:0] idx, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, idx, 32'h00000000, 4'hF, 10'h000);
    endtask

    task automatic irq_is(input logic e);
        @(posedge clk);
        chk({31'h00000000, irq}, {31'h00000000, e});
    endtask

    task automatic flags_zero;
        rd(`SGIF_IDX_REG_UV, 32'h00000000);
        rd(`SGIF_IDX_CONV_FLT, 32'h00000000);
        rd(`SGIF_IDX_PIN_EVT, 32'h00000000);
    endtask

    task automatic tally_and_finish;
        if (exp_q.size() != 0)
            fails++;
        $display("checks=%0d mismatches=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // read results are matched against the oldest expectation
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            fails++;
            tally_and_finish;
        end
        if (avs_read && avs_waitrequest === 1'b0)
        begin
            if (exp_q.size() > 0)
                chk(avs_readdata, exp_q.pop_front());
            else
                fails++;
        end
    end

    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        flags_zero;
        rd(`SGIF_IDX_MASK_REG_UV, 32'h000003FF);
        rd(`SGIF_IDX_MASK_CONV_FLT, 32'h0000030F);
        rd(`SGIF_IDX_MASK_PIN_EVT, 32'h00000FFF);
        wr(15'h0004, 32'hFFFFFFFF);
        rd(15'h0004, 32'h00000000);
        wr(`SGIF_IDX_MASK_REG_UV, 32'h00000000);
        wr(`SGIF_IDX_MASK_CONV_FLT, 32'h00000000);
        wr(`SGIF_IDX_MASK_PIN_EVT, 32'h00000000);
        irq_is(1'b0);
        e_reg = 16'h0000;
        e_conv = 16'h0000;
        for (k = 0; k < 6; k++)
        begin
            r = rnd();
            e_reg |= {6'h00, r[9:0] & ~reg_undervolt};
            e_conv |= {6'h00, r[15:14] & ~conv_overcurrent, 4'h0, r[13:10] & ~conv_undervolt};
            reg_undervolt <= r[9:0];
            conv_undervolt <= r[13:10];
            conv_overcurrent <= r[15:14];
            @(posedge clk);
            rd(`SGIF_IDX_REG_UV, {16'h0000, e_reg});
            rd(`SGIF_IDX_CONV_FLT, {16'h0000, e_conv});
            rd(`SGIF_IDX_LIVE_SUPPLY, {6'h00, r[15:14], 4'h0, r[13:10], 6'h00, r[9:0]});
            irq_is(|{e_reg, e_conv});
            r = rnd();
            wr(`SGIF_IDX_REG_UV, r);
            e_reg &= ~r[15:0];
            rd(`SGIF_IDX_REG_UV, {16'h0000, e_reg});
        end
        wr(`SGIF_IDX_REG_UV, 32'h0000FFFF);
        wr(`SGIF_IDX_CONV_FLT, 32'h0000FFFF);
        irq_is(1'b0);
        reg_undervolt <= 10'h001;
        @(posedge clk);
        reg_undervolt <= 10'h000;
        @(posedge clk);
        bus(1'b1, `SGIF_IDX_REG_UV, 32'h0000FFFF, 4'hF, 10'h201);
        rd(`SGIF_IDX_REG_UV, 32'h00000201);
        wr(`SGIF_IDX_REG_UV, 32'h0000FFFF);
        for (k = 0; k < 8; k++)
        begin
            r = rnd();
            trig = (k < 4) ? {12{k[1:0]}} : r[23:0];
            wr(`SGIF_IDX_TRIG_SEL, {8'h00, trig});
            rd(`SGIF_IDX_TRIG_SEL, {8'h00, trig});
            wr(`SGIF_IDX_PIN_EVT, 32'h0000FFFF);
            e_pin = 16'h0000;
            for (j = 0; j < 2; j++)
            begin
                r = rnd();
                e_pin |= {4'h0, hits(pin_level, r[11:0], trig)};
                pin_level <= r[11:0];
                @(posedge clk);
                rd(`SGIF_IDX_PIN_EVT, {16'h0000, e_pin});
            end
        end
        wr(`SGIF_IDX_TRIG_SEL, 32'h00AAAAAA);
        wr(`SGIF_IDX_PIN_EVT, 32'h0000FFFF);
        pin_level <= ~pin_level;
        @(posedge clk);
        bus(1'b1, `SGIF_IDX_PIN_EVT, 32'h0000FFFF, 4'h2, 10'h000);
        rd(`SGIF_IDX_PIN_EVT, 32'h000000FF);
        rd(`SGIF_IDX_PENDING, 32'h00000004);
        rd(`SGIF_IDX_LIVE_PIN, {20'h00000, pin_level});
        irq_is(1'b1);
        wr(`SGIF_IDX_MASK_PIN_EVT, 32'h00000FFF);
        irq_is(1'b0);
        wr(`SGIF_IDX_MASK_PIN_EVT, 32'h00000000);
        irq_is(1'b1);
        wr(`SGIF_IDX_PIN_EVT, 32'h0000FFFF);
        irq_is(1'b0);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        flags_zero;
        tally_and_finish;
    end
endmodule // supply_gpio_irq_flags_test
`default_nettype wire
